// >>> rtl/gdl_link.sv
// gauge driver serial command slave: 16-bit mode-1 receive, register decode, reply shift, pointer stepping
// assumes sclk, mosi and chip select come from an external master, asynchronous to clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module gdl_link
  import gdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic chip_select_n_in,
  input wire logic [7:0] status_in,
  output logic miso_out,
  output logic miso_oe_out,
  output gdl_config_t config_out,
  output gdl_velocity_t velocity_out,
  output logic [12:0] rtz_ctrl_out,
  output logic [12:0] rtz_cfg_out,
  output gdl_gauge_t gauge0_out,
  output gdl_gauge_t gauge1_out
);
  localparam logic [9:0] STEP_LAST = 10'(GDL_STEP_CYCLES - 1);

  typedef enum logic [1:0] {
    GDL_IDLE = 2'b00,
    GDL_SHIFT = 2'b01,
    GDL_DONE = 2'b11
  } gdl_state_t;

  // two-stage synchronisers; stage one is read only by stage two
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_d;
  logic sclk_s;
  logic mosi_s;
  logic csn_s;
  assign sclk_s = sync_b[0];
  assign mosi_s = sync_b[1];
  assign csn_s = sync_b[2];

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 3'h4;
      sync_b <= 3'h4;
      sclk_d <= 1'b0;
    end else begin
      sync_a <= {chip_select_n_in, mosi_in, sclk_in};
      sync_b <= sync_a;
      sclk_d <= sync_b[0];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  gdl_state_t state;
  gdl_state_t next_state;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [15:0] rx_sr;
  logic [15:0] next_rx_sr;
  logic [15:0] tx_sr;
  logic [15:0] next_tx_sr;
  logic miso;
  logic next_miso;
  logic first_edge;
  logic next_first_edge;
  logic word_ok;
  gdl_config_t cfg;
  gdl_config_t next_cfg;
  gdl_velocity_t vel;
  gdl_velocity_t next_vel;
  logic [12:0] rtz_ctrl;
  logic [12:0] next_rtz_ctrl;
  logic [12:0] rtz_cfg;
  logic [12:0] next_rtz_cfg;
  logic [11:0] target [2];
  logic [11:0] next_target [2];
  logic [11:0] pos [2];
  logic [11:0] next_pos [2];
  logic [9:0] pace;
  logic [9:0] next_pace;
  logic [1:0] step;
  logic [1:0] next_step;
  logic [1:0] dir;
  logic [1:0] next_dir;

  // reply word picked by the output selector at frame start
  function automatic logic [15:0] reply_word(input gdl_outsel_t sel, input logic [7:0] st,
                                             input logic [11:0] p, input logic [11:0] t);
    case (sel)
      GDL_OUT_STATUS: reply_word = {8'h00, st};
      GDL_OUT_ACCUM: reply_word = {4'h0, t};
      GDL_OUT_POS: reply_word = {4'h0, p};
      GDL_OUT_SPEED: reply_word = {4'h0, t - p};
      default: reply_word = 16'h0000;
    endcase
  endfunction

  // link state: frame framing, shifting and bit count
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx_sr = rx_sr;
    next_tx_sr = tx_sr;
    next_miso = miso;
    next_first_edge = first_edge;
    word_ok = 1'b0;
    case (state)
      GDL_IDLE: begin
        next_bit_cnt = 5'h00;
        next_first_edge = 1'b1;
        if (!csn_s) begin
          next_state = GDL_SHIFT;
          next_tx_sr = reply_word(cfg.out_select, status_in, pos[cfg.gauge_select],
                                  target[cfg.gauge_select]);
        end
      end
      GDL_SHIFT: begin
        // mode 1: drive on each rising edge, sample on each falling edge
        if (sclk_rise) begin
          next_miso = tx_sr[15];
          next_tx_sr = {tx_sr[14:0], 1'b0};
          next_first_edge = 1'b0;
        end
        if (sclk_fall && !first_edge) begin
          next_rx_sr = {rx_sr[14:0], mosi_s};
          // saturate so an overlong frame can never wrap back to a count of sixteen
          if (bit_cnt != 5'h1f) begin
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
        if (csn_s) begin
          next_state = GDL_DONE;
        end
      end
      GDL_DONE: begin
        // only a whole 16-bit frame is acted upon
        word_ok = (bit_cnt == 5'(GDL_WORD_BITS));
        next_state = GDL_IDLE;
      end
      default: next_state = GDL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= GDL_IDLE;
      bit_cnt <= 5'h00;
      rx_sr <= 16'h0000;
      tx_sr <= 16'h0000;
      miso <= 1'b0;
      first_edge <= 1'b1;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_sr <= next_rx_sr;
      tx_sr <= next_tx_sr;
      miso <= next_miso;
      first_edge <= next_first_edge;
    end
  end

  // register file written at the end of each complete frame
  logic [2:0] addr;
  logic [12:0] data;
  assign addr = rx_sr[GDL_ADDR_MSB:GDL_ADDR_LSB];
  assign data = rx_sr[12:0];

  always_comb begin
    next_cfg = cfg;
    next_vel = vel;
    next_rtz_ctrl = rtz_ctrl;
    next_rtz_cfg = rtz_cfg;
    next_target = target;
    if (word_ok) begin
      case (addr)
        GDL_REG_CONFIG: begin
          next_cfg.status_only_command_on = data[GDL_CFG_NULL];
          // a null command leaves every other setting as it was
          if (!data[GDL_CFG_NULL]) begin
            next_cfg.out_select = gdl_outsel_t'(data[GDL_CFG_SEL_LSB +: 2]);
            next_cfg.gauge_select = data[GDL_CFG_GSEL];
            next_cfg.zero_at_clockwise_end = data[GDL_CFG_ZERO_CW];
            next_cfg.meter_emulation_on = data[GDL_CFG_EMUL];
            next_cfg.calibrate_typical_freq = data[GDL_CFG_CAL_FREQ];
            next_cfg.calibration_on = data[GDL_CFG_CAL_ON];
            next_cfg.osc_period_two_thirds = data[GDL_CFG_OSC];
            next_cfg.second_gauge_drive_on = data[GDL_CFG_G1_ON];
            next_cfg.first_gauge_drive_on = data[GDL_CFG_G0_ON];
          end
        end
        GDL_REG_VELOCITY: begin
          // index 0 is outside the table and is ignored
          if (data[GDL_VEL_IDX_LSB +: 8] != 8'h00) begin
            next_vel.index = data[GDL_VEL_IDX_LSB +: 8];
          end
          next_vel.velocity_limit_first_gauge = data[GDL_VEL_G0];
          next_vel.velocity_limit_second_gauge = data[GDL_VEL_G1];
        end
        GDL_REG_POS0: next_target[0] = data[11:0];
        GDL_REG_POS1: next_target[1] = data[11:0];
        GDL_REG_RTZ_CTRL: next_rtz_ctrl = data;
        GDL_REG_RTZ_CFG: next_rtz_cfg = data;
        default: next_cfg = cfg;
      endcase
    end
  end

  // pointer stepping toward target, one step per pace period
  always_comb begin
    logic [1:0] on;
    // judged on the config that holds after this edge, so a step never shows beside a cleared enable
    on = {next_cfg.second_gauge_drive_on, next_cfg.first_gauge_drive_on};
    next_pos = pos;
    next_step = 2'b00;
    next_dir = dir;
    next_pace = (pace == STEP_LAST) ? 10'h000 : pace + 10'h001;
    for (int g = 0; g < 2; g++) begin
      if (pace == STEP_LAST && on[g] && pos[g] != target[g]) begin
        next_step[g] = 1'b1;
        next_dir[g] = (target[g] > pos[g]);
        next_pos[g] = (target[g] > pos[g]) ? pos[g] + 12'h001 : pos[g] - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg <= '0;
      vel <= '{velocity_limit_second_gauge: 1'b0, velocity_limit_first_gauge: 1'b0, index: GDL_VEL_RESET};
      rtz_ctrl <= GDL_DATA_RESET;
      rtz_cfg <= GDL_DATA_RESET;
      target[0] <= GDL_POS_RESET;
      target[1] <= GDL_POS_RESET;
      pos[0] <= GDL_POS_RESET;
      pos[1] <= GDL_POS_RESET;
      pace <= 10'h000;
      step <= 2'b00;
      dir <= 2'b00;
    end else begin
      cfg <= next_cfg;
      vel <= next_vel;
      rtz_ctrl <= next_rtz_ctrl;
      rtz_cfg <= next_rtz_cfg;
      target <= next_target;
      pos <= next_pos;
      pace <= next_pace;
      step <= next_step;
      dir <= next_dir;
    end
  end

  assign miso_out = miso;
  assign miso_oe_out = ~csn_s;
  assign config_out = cfg;
  assign velocity_out = vel;
  assign rtz_ctrl_out = rtz_ctrl;
  assign rtz_cfg_out = rtz_cfg;
  // gauge outputs are flops only; a disabled gauge never steps, so no mask gate is needed here
  assign gauge0_out = '{pos: pos[0], step_pulse: step[0],
                        dir_up: dir[0], drive_on: cfg.first_gauge_drive_on};
  assign gauge1_out = '{pos: pos[1], step_pulse: step[1],
                        dir_up: dir[1], drive_on: cfg.second_gauge_drive_on};
endmodule
`default_nettype wire

// >>> rtl/gdl_pkg.sv
// package for the gauge driver serial command link: register codes, field layout, status selector
// assumes a 50 MHz system clock and an external master running mode 1 (cpol 0, cpha 1)
// Functional notes
// - words shift most significant bit first in both directions.
// - clock phase one: data changes on the first edge, sampled on the second.
// - every command word is exactly sixteen bits long.
// - top three bits select one of six registers; codes 110 and 111 ignored.
// - the driver accepts commands and returns the selected reply word during each transfer.
// - a config selector chooses status, accumulator, position or speed on the output.
// - a null command enable lets the master read status without changing settings; here the reply still follows the output selector.
// - config picks one gauge and sets its zero at clockwise or anticlockwise end.
// - config holds emulation, calibration frequency, calibration enable and oscillator trim.
// - each gauge has its own output drive enable; disabled gauge drives nothing.
// - velocity register carries table index 1 to 255 and per gauge apply flags.
// - each position register takes a target 0 to 4095; the pointer moves there.
package gdl_pkg;
  localparam int unsigned GDL_WORD_BITS = 16;
  localparam int unsigned GDL_ADDR_MSB = 15;
  localparam int unsigned GDL_ADDR_LSB = 13;
  localparam logic [2:0] GDL_REG_CONFIG = 3'h0;
  localparam logic [2:0] GDL_REG_VELOCITY = 3'h1;
  localparam logic [2:0] GDL_REG_POS0 = 3'h2;
  localparam logic [2:0] GDL_REG_POS1 = 3'h3;
  localparam logic [2:0] GDL_REG_RTZ_CTRL = 3'h4;
  localparam logic [2:0] GDL_REG_RTZ_CFG = 3'h5;
  // config field positions inside the 13-bit data field
  localparam int unsigned GDL_CFG_G0_ON = 0;
  localparam int unsigned GDL_CFG_G1_ON = 1;
  localparam int unsigned GDL_CFG_OSC = 2;
  localparam int unsigned GDL_CFG_CAL_ON = 3;
  localparam int unsigned GDL_CFG_CAL_FREQ = 4;
  localparam int unsigned GDL_CFG_EMUL = 5;
  localparam int unsigned GDL_CFG_ZERO_CW = 6;
  localparam int unsigned GDL_CFG_GSEL = 7;
  localparam int unsigned GDL_CFG_SEL_LSB = 8;
  localparam int unsigned GDL_CFG_NULL = 10;
  // velocity field positions
  localparam int unsigned GDL_VEL_IDX_LSB = 0;
  localparam int unsigned GDL_VEL_G0 = 8;
  localparam int unsigned GDL_VEL_G1 = 9;
  localparam logic [7:0] GDL_VEL_RESET = 8'h01;
  localparam logic [11:0] GDL_POS_RESET = 12'h000;
  localparam logic [12:0] GDL_DATA_RESET = 13'h0000;
  // step pacing: one pointer step per this many system clocks
  localparam int unsigned GDL_STEP_CYCLES = 1000;

  typedef enum logic [1:0] {
    GDL_OUT_STATUS = 2'h0,
    GDL_OUT_ACCUM = 2'h1,
    GDL_OUT_POS = 2'h2,
    GDL_OUT_SPEED = 2'h3
  } gdl_outsel_t;

  typedef struct packed {
    logic status_only_command_on;
    gdl_outsel_t out_select;
    logic gauge_select;
    logic zero_at_clockwise_end;
    logic meter_emulation_on;
    logic calibrate_typical_freq;
    logic calibration_on;
    logic osc_period_two_thirds;
    logic second_gauge_drive_on;
    logic first_gauge_drive_on;
  } gdl_config_t;

  typedef struct packed {
    logic velocity_limit_second_gauge;
    logic velocity_limit_first_gauge;
    logic [7:0] index;
  } gdl_velocity_t;

  typedef struct packed {
    logic [11:0] pos;
    logic step_pulse;
    logic dir_up;
    logic drive_on;
  } gdl_gauge_t;
endpackage

// >>> tb/gdl_link_asserts.sv
// checker for the gauge driver serial command slave, bound to gdl_link
// assumes the master keeps chip select high at least 3 clocks between frames
`timescale 1ns/100ps
`default_nettype none
module gdl_link_asserts
  import gdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire gdl_config_t config_out,
  input wire gdl_velocity_t velocity_out,
  input wire logic [12:0] rtz_ctrl_out,
  input wire logic [12:0] rtz_cfg_out,
  input wire gdl_gauge_t gauge0_out,
  input wire gdl_gauge_t gauge1_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic [3:0] framed_cnt;
  logic [3:0] next_framed_cnt;
  always_comb begin
    next_framed_cnt = chip_select_n_in ? 4'h0 : framed_cnt + {3'h0, framed_cnt != 4'hf};
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) framed_cnt <= 4'h0;
    else framed_cnt <= next_framed_cnt;
  end
  sequence s_idle_long;
    chip_select_n_in && $past(chip_select_n_in, 5);
  endsequence
  a_oe_on_select: assert property ($fell(chip_select_n_in) |-> ##[1:4] miso_oe_out) else $error("oe late");
  a_oe_off_release: assert property ($rose(chip_select_n_in) |-> ##[1:4] !miso_oe_out) else $error("oe stuck");
  a_cfg_hold_framed: assert property (framed_cnt >= 4'h8 |-> $stable(config_out)) else $error("cfg mid frame");
  a_regs_hold_idle: assert property (s_idle_long |-> $stable(velocity_out) && $stable(rtz_ctrl_out)
    && $stable(rtz_cfg_out)) else $error("reg change idle");
  a_vel_index_legal: assert property (velocity_out.index != 8'h00) else $error("index zero");
  a_g0_step_drive: assert property (gauge0_out.step_pulse
    |-> gauge0_out.drive_on && $changed(gauge0_out.pos)) else $error("g0 step off");
  a_g1_step_drive: assert property (gauge1_out.step_pulse
    |-> gauge1_out.drive_on && $changed(gauge1_out.pos)) else $error("g1 step off");
  a_g0_parked_off: assert property (!gauge0_out.drive_on |-> $stable(gauge0_out.pos))
    else $error("g0 moved off");
  a_g1_parked_off: assert property (!gauge1_out.drive_on |-> $stable(gauge1_out.pos))
    else $error("g1 moved off");
  a_step_pulse_short: assert property (gauge0_out.step_pulse |=> !gauge0_out.step_pulse [*8])
    else $error("step too long");
  a_miso_hold_low: assert property (!sclk_in && !$past(sclk_in, 3) && miso_oe_out && $past(miso_oe_out, 3)
    |-> $stable(miso_out)) else $error("miso moved");
endmodule
bind gdl_link gdl_link_asserts i_asserts(.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .sclk_in(sclk_in),
  .chip_select_n_in(chip_select_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .config_out(config_out),
  .velocity_out(velocity_out), .rtz_ctrl_out(rtz_ctrl_out), .rtz_cfg_out(rtz_cfg_out), .gauge0_out(gauge0_out),
  .gauge1_out(gauge1_out));
`default_nettype wire

// >>> tb/gdl_host_model.sv
// host serial master model: mode 1, msb first, 160 ns link period
// assumes the bench clock is 20 ns; all pins change at its falling edge
`timescale 1ns/100ps
`default_nettype none
module gdl_host_model (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic cs_n_out
);
  initial begin
    sclk_out = 1'b0;
    mosi_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // polled transfer, only the master starts it; short counts model a broken frame
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
    reply = 16'h0000;
    cs_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'b1;
      mosi_out = word[15-i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
      reply = {reply[14:0], miso_in};
      repeat (4) @(negedge clk_in);
    end
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (6) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/gdl_link_bench.sv
// bench for gdl_link: register writes and reply reads through the host model
// assumes the checker is bound in from its own file
`timescale 1ns/100ps
`default_nettype none
module gdl_link_bench;
  import gdl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] status_in = 8'h00;
  wire sclk;
  wire mosi;
  wire cs_n;
  logic miso_out, miso_oe_out;
  logic miso_last = 1'b0;
  gdl_config_t config_out;
  gdl_velocity_t velocity_out;
  logic [12:0] rtz_ctrl_out, rtz_cfg_out;
  gdl_gauge_t gauge0_out, gauge1_out;
  int miscompares = 0;
  int n_compared = 0;
  logic [15:0] r;
  logic [15:0] exp_r [4] = '{16'h00a5, 16'h0fff, 16'h0000, 16'h0fff};
  always #10 clk_sys_in = ~clk_sys_in;
  // released line shows the inverse of its last level, not a kind constant
  always @(posedge clk_sys_in) if (miso_oe_out) miso_last <= miso_out;
  wire miso_w = miso_oe_out ? miso_out : ~miso_last;
  gdl_link i_dut(.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .sclk_in(sclk), .mosi_in(mosi),
    .chip_select_n_in(cs_n), .status_in(status_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .config_out(config_out), .velocity_out(velocity_out), .rtz_ctrl_out(rtz_ctrl_out),
    .rtz_cfg_out(rtz_cfg_out), .gauge0_out(gauge0_out), .gauge1_out(gauge1_out));
  gdl_host_model i_host(.clk_in(clk_sys_in), .miso_in(miso_w), .sclk_out(sclk), .mosi_out(mosi), .cs_n_out(cs_n));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input logic [2:0] a, input logic [12:0] d);
    i_host.xfer({a, d}, 16, r);
  endtask
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    check("cfg reset", 16'(config_out), 16'h0000);
    check("vel reset", 16'(velocity_out), 16'h0001);
    status_in = 8'ha5;
    // start-up order: gauges off with calibration on, status read back in the same frame
    send(GDL_REG_CONFIG, 13'h006c);
    check("status reply", r, 16'h00a5);
    check("cfg fields", 16'(config_out), 16'h006c);
    send(GDL_REG_POS0, 13'h0fff);
    // gauge stays parked while its drive is off, so position and speed are known
    for (int s = 0; s < 4; s++) begin
      send(GDL_REG_CONFIG, {3'h0, 2'(s), 8'h6c});
      send(3'h6, 13'h1555);
      check("selected reply", r, exp_r[s]);
      check("cfg after 6", 16'(config_out), {6'h0, 2'(s), 8'h6c});
    end
    send(3'h7, 13'h1fff);
    check("cfg after 7", 16'(config_out), 16'h036c);
    send(GDL_REG_VELOCITY, 13'h0300);
    check("vel index 0", 16'(velocity_out), 16'h0301);
    send(GDL_REG_VELOCITY, 13'h01ff);
    check("vel index 255", 16'(velocity_out), 16'h01ff);
    send(GDL_REG_RTZ_CTRL, 13'h1abc);
    send(GDL_REG_RTZ_CFG, 13'h0543);
    check("rtz ctrl", 16'(rtz_ctrl_out), 16'h1abc);
    check("rtz cfg", 16'(rtz_cfg_out), 16'h0543);
    i_host.xfer({GDL_REG_RTZ_CTRL, 13'h0001}, 15, r);
    check("short frame", 16'(rtz_ctrl_out), 16'h1abc);
    send(GDL_REG_CONFIG, 13'h0401);
    check("null cmd", 16'(config_out), 16'h076c);
    send(GDL_REG_POS1, 13'h0123);
    send(GDL_REG_CONFIG, 13'h01ec);
    send(3'h6, 13'h0000);
    check("g1 accum reply", r, 16'h0123);
    check("g1 select", 16'(config_out), 16'h01ec);
    send(GDL_REG_CONFIG, 13'h006d);
    repeat (3000) @(negedge clk_sys_in);
    check("g0 moving", 16'(gauge0_out.pos > 12'h000), 16'h0001);
    check("g0 dir", 16'(gauge0_out.dir_up), 16'h0001);
    check("g0 drive", 16'(gauge0_out.drive_on), 16'h0001);
    check("g1 drive", 16'(gauge1_out.drive_on), 16'h0000);
    check("g1 parked", 16'(gauge1_out.pos), 16'h0000);
    send(GDL_REG_CONFIG, 13'h006e);
    r = 16'(gauge0_out.pos);
    repeat (3000) @(negedge clk_sys_in);
    check("g1 moving", 16'(gauge1_out.pos > 12'h000), 16'h0001);
    check("g1 dir", 16'(gauge1_out.dir_up), 16'h0001);
    check("g0 off", 16'(gauge0_out.drive_on), 16'h0000);
    check("g0 held", 16'(gauge0_out.pos), r);
    // second reset in mid-run, with the host idle
    arst_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    check("cfg after reset", 16'(config_out), 16'h0000);
    check("vel after reset", 16'(velocity_out), 16'h0001);
    check("g1 after reset", 16'(gauge1_out.pos), 16'h0000);
    send(GDL_REG_CONFIG, 13'h0000);
    check("reply after reset", r, 16'h00a5);
    end_sim();
  end
endmodule
`default_nettype wire
